/* File: hdl/pup_ctrl.sv */
// Power-up mode select, calibration autoload and register slave.
// Assumes serial framing elsewhere delivers one-cycle pulses, inputs
// synchronous to clk, and a classic Wishbone master.
`timescale 1ns/1ps
// Function
// R1 - At power-up the setup word is read from flash first and gives wait time and word count.
// R2 - When the wait time runs out without enough control words the mode becomes analog.
// R3 - Enough control words inside the wait time enter programming mode.
// R4 - In programming mode the go-analog command switches to analog mode.
// R5 - A repeat field of 111 enters programming mode with no control words.
// R6 - The programmer must still send the initialization byte before serial traffic is accepted.
// R7 - Erased factory flash starts the part in programming mode.
// R8 - Every power-up autoloads the calibration registers from flash.
// R9 - In programming mode calibration registers are written directly, without flash.
// R10 - The span table has 176 entries indexed by temperature index 0 to 175.
// R11 - The offset table has 176 entries indexed by temperature index.
// R12 - The programmer writes tables, coefficients, configurations and setup word to flash.
// R13 - Analog mode, once entered, holds until the next power-up.
module pup_ctrl #(
  parameter int BYTE_CYCLES = pup_pkg::BYTE_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ctrl_word_rx,
  input  wire logic        init_byte_rx,
  input  wire logic        analog_cmd_rx,
  input  wire logic [7:0]  temperature_index,
  output logic             prog_mode,
  output logic             analog_mode,
  output logic             serial_accept,
  output logic             load_done,
  output logic      [15:0] offset_level_dac,
  output logic      [15:0] span_dac,
  output logic      [15:0] offset_temp_coeff_dac,
  output logic      [15:0] span_temp_coeff_dac,
  output logic      [15:0] configuration_one,
  output logic      [15:0] configuration_two
);
  import pup_pkg::*;

  localparam int PW = $clog2(BYTE_CYCLES + 1);

  if (BYTE_CYCLES < 1 || BYTE_CYCLES > 65535) begin : g_chk
    $error("BYTE_CYCLES out of range");
  end

  pup_state_t  st;
  logic [2:0]  step;
  logic        rd_pend;
  logic        issue;
  logic [8:0]  rd_addr;
  logic [15:0] setup_word;
  logic [PW-1:0] pre_cnt;
  logic [14:0] byte_cnt;
  logic [3:0]  words_seen;
  logic [3:0]  need;
  logic        byte_tick;
  logic        wait_over;
  logic        word_done;
  logic        bypass;
  logic        init_seen;
  logic        bus_req;
  logic        bus_wr;
  logic        fl_wr;
  logic        go_analog;
  logic [8:0]  faddr;

  pup_mem_if #(.AW(FLASH_AW), .DW(FLASH_DW)) mem ();

  pup_flash_mem #(.AW(FLASH_AW), .DW(FLASH_DW)) u_flash (
    .clk  (clk),
    .port (mem)
  );

  // Out-of-range indices clamp to the last entry
  function automatic logic [8:0] lut_addr(input logic [8:0] base,
                                          input logic [7:0] ti);
    logic [7:0] idx;
    idx = (ti > TIDX_MAX) ? TIDX_MAX : ti;
    return base + {1'b0, idx};
  endfunction : lut_addr

  function automatic logic [8:0] load_addr(input logic [2:0] s,
                                           input logic [7:0] ti);
    case (s)
      STEP_SETUP: return SETUP_ADDR;
      STEP_OTC:   return OTC_ADDR;
      STEP_STC:   return STC_ADDR;
      STEP_CFG1:  return CFG1_ADDR;
      STEP_CFG2:  return CFG2_ADDR;
      STEP_OFS:   return lut_addr(OFS_LUT_BASE, ti);
      default:    return lut_addr(SPAN_LUT_BASE, ti);
    endcase
  endfunction : load_addr

  // Codes above the top one saturate
  function automatic logic [14:0] wait_bytes(input logic [3:0] code);
    logic [3:0] c;
    c = (code > WAIT_CODE_MAX) ? WAIT_CODE_MAX : code;
    return (15'h0001 << c) + 15'h0001;
  endfunction : wait_bytes

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction : merge16

  assign bypass    = setup_word[REP_LSB +: 3] == REP_BYPASS;
  assign need      = {1'b0, setup_word[REP_LSB +: 3]} + 4'h1;
  assign byte_tick = pre_cnt == PW'(BYTE_CYCLES - 1);
  assign wait_over = byte_tick &&
    (byte_cnt == wait_bytes(setup_word[WAIT_LSB +: 4]) - 15'h0001);
  assign word_done = ctrl_word_rx && (words_seen + 4'h1 == need);
  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr    = ce && bus_req && wb_we_i;
  assign fl_wr     = bus_wr && wb_adr_i == REG_FDATA && st == ST_PROG;
  assign go_analog = analog_cmd_rx ||
    (bus_wr && wb_adr_i == REG_CMD && wb_sel_i[0] && wb_dat_i[0]);

  // Flash reads only outside programming mode, so no port conflict
  assign issue     = !rd_pend && (st == ST_LOAD || st == ST_ANALOG);
  assign rd_addr   = load_addr(step, temperature_index); // R10 R11
  assign mem.en    = ce && (issue || fl_wr);
  assign mem.we    = fl_wr; // R12
  assign mem.addr  = fl_wr ? faddr : rd_addr;
  assign mem.wdata = wb_dat_i[15:0];

  assign prog_mode   = st[PROG_BIT];
  assign analog_mode = st[ANALOG_BIT];

  // Mode sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_LOAD;
    end else if (ce) begin
      unique case (st)
        ST_LOAD: begin
          if (rd_pend && step == STEP_SPAN) begin
            st <= bypass ? ST_PROG : ST_WAIT; // R1 R5 R7
          end
        end
        ST_WAIT: begin
          if (word_done) begin
            st <= ST_PROG; // R3
          end else if (wait_over) begin
            st <= ST_ANALOG; // R2
          end
        end
        ST_PROG: begin
          if (go_analog) begin
            st <= ST_ANALOG; // R4
          end
        end
        ST_ANALOG: st <= ST_ANALOG; // R13
      endcase
    end
  end

  // Flash read pacing: one read in flight, captured next cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend <= 1'b0;
      step    <= STEP_SETUP;
    end else if (ce) begin
      rd_pend <= issue;
      if (rd_pend) begin
        if (st == ST_LOAD && step != STEP_SPAN) begin
          step <= step + 3'h1; // R8
        end else begin
          step <= (step == STEP_SPAN) ? STEP_OFS : STEP_SPAN;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      load_done <= 1'b0;
    end else if (ce && st == ST_LOAD && rd_pend && step == STEP_SPAN) begin
      load_done <= 1'b1;
    end
  end

  // Wait window: byte-time prescaler, byte count, control words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt    <= '0;
      byte_cnt   <= 15'h0000;
      words_seen <= 4'h0;
    end else if (ce && st == ST_WAIT) begin
      if (byte_tick) begin
        pre_cnt  <= '0;
        byte_cnt <= byte_cnt + 15'h0001; // R2
      end else begin
        pre_cnt <= pre_cnt + PW'(1);
      end
      if (ctrl_word_rx) begin
        words_seen <= words_seen + 4'h1; // R3
      end
    end
  end

  // Traffic is only let through once the initialization byte is seen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_seen     <= 1'b0;
      serial_accept <= 1'b0;
    end else if (ce) begin
      if (init_byte_rx && (st == ST_WAIT || st == ST_PROG)) begin
        init_seen <= 1'b1; // R6
      end
      serial_accept <= st == ST_PROG && (init_seen || init_byte_rx); // R6
    end
  end

  // Calibration registers: autoload, table refresh, direct writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_word            <= DAC_RESET;
      offset_level_dac      <= DAC_RESET;
      span_dac              <= DAC_RESET;
      offset_temp_coeff_dac <= DAC_RESET;
      span_temp_coeff_dac   <= DAC_RESET;
      configuration_one     <= DAC_RESET;
      configuration_two     <= DAC_RESET;
    end else if (ce) begin
      if (rd_pend) begin
        case (step)
          STEP_SETUP: setup_word            <= mem.rdata; // R1
          STEP_OTC:   offset_temp_coeff_dac <= mem.rdata; // R8
          STEP_STC:   span_temp_coeff_dac   <= mem.rdata; // R8
          STEP_CFG1:  configuration_one     <= mem.rdata; // R8
          STEP_CFG2:  configuration_two     <= mem.rdata; // R8
          STEP_OFS:   offset_level_dac      <= mem.rdata; // R11
          default:    span_dac              <= mem.rdata; // R10
        endcase
      end
      if (bus_wr && st == ST_PROG) begin
        case (wb_adr_i)
          REG_OFFSET_LEVEL_DAC: offset_level_dac <=
            merge16(offset_level_dac, wb_dat_i, wb_sel_i); // R9
          REG_SPAN: span_dac <= merge16(span_dac, wb_dat_i, wb_sel_i); // R9
          REG_OTC: offset_temp_coeff_dac <=
            merge16(offset_temp_coeff_dac, wb_dat_i, wb_sel_i); // R9
          REG_STC: span_temp_coeff_dac <=
            merge16(span_temp_coeff_dac, wb_dat_i, wb_sel_i); // R9
          REG_CFG1: configuration_one <=
            merge16(configuration_one, wb_dat_i, wb_sel_i); // R9
          REG_CFG2: configuration_two <=
            merge16(configuration_two, wb_dat_i, wb_sel_i); // R9
          default: ;
        endcase
      end
    end
  end

  // Flash address pointer, advances after each flash data write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      faddr <= 9'h000;
    end else if (fl_wr) begin
      faddr <= faddr + 9'h001;
    end else if (bus_wr && wb_adr_i == REG_FADDR && wb_sel_i[0]) begin
      faddr <= wb_dat_i[8:0];
    end
  end

  // Wishbone slave: answer one cycle after the request, any address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          REG_STATUS: wb_dat_o <= {20'h0_0000, words_seen, init_seen,
                                   load_done, 2'b00, st};
          REG_OFFSET_LEVEL_DAC:   wb_dat_o <= {16'h0000, offset_level_dac};
          REG_SPAN:   wb_dat_o <= {16'h0000, span_dac};
          REG_OTC:    wb_dat_o <= {16'h0000, offset_temp_coeff_dac};
          REG_STC:    wb_dat_o <= {16'h0000, span_temp_coeff_dac};
          REG_CFG1:   wb_dat_o <= {16'h0000, configuration_one};
          REG_CFG2:   wb_dat_o <= {16'h0000, configuration_two};
          REG_FADDR:  wb_dat_o <= {23'h00_0000, faddr};
          REG_TIDX:   wb_dat_o <= {24'h00_0000, temperature_index};
          default:    wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_load_end;
    st == ST_LOAD && rd_pend && step == STEP_SPAN && ce;
  endsequence
  sequence s_prog_write(logic [7:0] off);
    st == ST_PROG && bus_wr && wb_adr_i == off && wb_sel_i[1:0] == 2'b11;
  endsequence

  setup_first_a: assert property ( // R1
    st == ST_LOAD && step == STEP_SETUP && issue |-> rd_addr == SETUP_ADDR)
    else $error("first load read is not the setup word");
  expire_analog_a: assert property ( // R2
    st == ST_WAIT && ce && wait_over && !word_done |=> st == ST_ANALOG)
    else $error("wait expiry did not enter analog mode");
  words_prog_a: assert property ( // R3
    st == ST_WAIT && ce && word_done |=> st == ST_PROG)
    else $error("control words did not enter programming mode");
  cmd_analog_a: assert property ( // R4
    st == ST_PROG && ce && go_analog |=> st == ST_ANALOG)
    else $error("go-analog command ignored");
  bypass_prog_a: assert property ( // R5
    s_load_end ##0 bypass |=> st == ST_PROG)
    else $error("bypass did not enter programming mode");
  wait_path_a: assert property ( // R1
    s_load_end ##0 !bypass |=> st == ST_WAIT && words_seen == 4'h0)
    else $error("load did not open the wait window");
  autoload_otc_a: assert property ( // R8
    st == ST_LOAD && rd_pend && step == STEP_OTC && ce
    |=> offset_temp_coeff_dac == $past(mem.rdata))
    else $error("offset TC not autoloaded");
  direct_write_a: assert property ( // R9
    s_prog_write(REG_OFFSET_LEVEL_DAC) |=> offset_level_dac == $past(wb_dat_i[15:0]))
    else $error("direct offset write not applied");
  span_lut_a: assert property ( // R10
    issue && step == STEP_SPAN
    |-> rd_addr == lut_addr(SPAN_LUT_BASE, temperature_index)
        && rd_addr < SPAN_LUT_BASE + 9'(LUT_ENTRIES))
    else $error("span table address wrong");
  ofs_lut_a: assert property ( // R11
    issue && step == STEP_OFS |-> rd_addr < OFS_LUT_BASE + 9'(LUT_ENTRIES))
    else $error("offset table address wrong");
  analog_hold_a: assert property ( // R13
    st == ST_ANALOG |=> (st == ST_ANALOG) [*4])
    else $error("left analog mode");
endmodule : pup_ctrl

/* File: pkg/pup_pkg.sv */
// Constants, layout and types of the power-up mode select and autoload block.
// Assumes one clock domain; flash holds 16-bit words.
package pup_pkg;
  localparam int FLASH_AW = 9;
  localparam int FLASH_DW = 16;
  localparam int LUT_ENTRIES = 176;
  localparam logic [7:0] TIDX_MAX = 8'hAF;
  // Flash word map
  localparam logic [8:0] OFS_LUT_BASE  = 9'h000;
  localparam logic [8:0] SPAN_LUT_BASE = 9'h0B0;
  localparam logic [8:0] OTC_ADDR      = 9'h160;
  localparam logic [8:0] STC_ADDR      = 9'h161;
  localparam logic [8:0] CFG1_ADDR     = 9'h162;
  localparam logic [8:0] CFG2_ADDR     = 9'h163;
  localparam logic [8:0] SETUP_ADDR    = 9'h164;
  // Erased flash reads all ones, so the repeat field reads as bypass
  localparam logic [15:0] FLASH_ERASED = 16'hFFFF;
  localparam logic [15:0] DAC_RESET    = 16'h0000;
  // Power-up setup word fields
  localparam int WAIT_LSB = 0;
  localparam int REP_LSB  = 4;
  localparam logic [2:0] REP_BYPASS    = 3'h7;
  localparam logic [3:0] WAIT_CODE_MAX = 4'hE;
  // Autoload steps
  localparam logic [2:0] STEP_SETUP = 3'h0;
  localparam logic [2:0] STEP_OTC   = 3'h1;
  localparam logic [2:0] STEP_STC   = 3'h2;
  localparam logic [2:0] STEP_CFG1  = 3'h3;
  localparam logic [2:0] STEP_CFG2  = 3'h4;
  localparam logic [2:0] STEP_OFS   = 3'h5;
  localparam logic [2:0] STEP_SPAN  = 3'h6;
  // Wishbone byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_OFFSET_LEVEL_DAC   = 8'h08;
  localparam logic [7:0] REG_SPAN   = 8'h0C;
  localparam logic [7:0] REG_OTC    = 8'h10;
  localparam logic [7:0] REG_STC    = 8'h14;
  localparam logic [7:0] REG_CFG1   = 8'h18;
  localparam logic [7:0] REG_CFG2   = 8'h1C;
  localparam logic [7:0] REG_FADDR  = 8'h20;
  localparam logic [7:0] REG_FDATA  = 8'h24;
  localparam logic [7:0] REG_TIDX   = 8'h28;
  localparam int BYTE_CYCLES_DEF = 8;
  localparam int PROG_BIT   = 2;
  localparam int ANALOG_BIT = 3;
  typedef enum logic [3:0] {
    ST_LOAD   = 4'b0001,
    ST_WAIT   = 4'b0010,
    ST_PROG   = 4'b0100,
    ST_ANALOG = 4'b1000
  } pup_state_t;
endpackage : pup_pkg

/* File: pkg/pup_mem_if.sv */
// Port between the controller and its flash store.
// Read data is valid the cycle after an enabled read.
`timescale 1ns/1ps
interface pup_mem_if #(parameter int AW = 9, parameter int DW = 16);
  logic          en;
  logic          we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output en, output we, output addr, output wdata,
                input rdata);
  modport mem  (input en, input we, input addr, input wdata,
                output rdata);
endinterface : pup_mem_if

/* File: hdl/pup_flash_mem.sv */
// Flash word store with registered read data.
// Assumes the caller gates enable with its clock enable.
`timescale 1ns/1ps
module pup_flash_mem #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  input wire logic clk,
  pup_mem_if.mem   port
);
  import pup_pkg::*;
  logic [DW-1:0] store [0:(1<<AW)-1];

  // Flash words are 16 bits; the address must reach the setup word
  if (AW < FLASH_AW || AW > 16 || DW != FLASH_DW) begin : g_chk
    $error("flash store geometry not supported");
  end

  // Factory state is erased flash: all ones
  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      store[i] = DW'(FLASH_ERASED); // R7
    end
  end

  always_ff @(posedge clk) begin
    if (port.en) begin
      if (port.we) begin
        store[port.addr] <= port.wdata;
      end
      port.rdata <= store[port.addr];
    end
  end
endmodule : pup_flash_mem

/* File: tb/pup_prog_model.sv */
// Calibration programmer model driving the serial front-end pulses.
// Assumes pulses are sampled on rising clk edges.
`timescale 1ns/1ps
module pup_prog_model (
  input  wire logic clk,
  output logic      ctrl_word_rx,
  output logic      init_byte_rx,
  output logic      analog_cmd_rx
);
  initial begin
    ctrl_word_rx  = 1'b0;
    init_byte_rx  = 1'b0;
    analog_cmd_rx = 1'b0;
  end
  // Slow programmer passes a gap; prompt one passes zero
  task automatic send_ctrl(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      ctrl_word_rx <= 1'b1;
      @(posedge clk);
      ctrl_word_rx <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask : send_ctrl
  task automatic send_init();
    @(posedge clk);
    init_byte_rx <= 1'b1;
    @(posedge clk);
    init_byte_rx <= 1'b0;
  endtask : send_init
  task automatic send_analog();
    @(posedge clk);
    analog_cmd_rx <= 1'b1;
    @(posedge clk);
    analog_cmd_rx <= 1'b0;
  endtask : send_analog
endmodule : pup_prog_model

/* File: tb/test_pup_ctrl.sv */
// Self-checking bench for the power-up mode select and autoload block.
// Assumes flash contents survive rst_n, as on a real power cycle.
`timescale 1ns/1ps
module test_pup_ctrl;
  import pup_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ctrl_word_rx, init_byte_rx, analog_cmd_rx;
  logic [7:0]  temp_idx = 8'h00;
  logic        prog_mode, analog_mode, serial_accept, load_done;
  logic [15:0] ofs_dac, span_dac, otc_dac, stc_dac, cfg1, cfg2;
  logic [31:0] rd;
  int          bad_count = 0;
  int          n_compared = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  pup_ctrl #(.BYTE_CYCLES(2)) u_pup_ctrl (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ctrl_word_rx(ctrl_word_rx), .init_byte_rx(init_byte_rx),
    .analog_cmd_rx(analog_cmd_rx), .temperature_index(temp_idx),
    .prog_mode(prog_mode), .analog_mode(analog_mode),
    .serial_accept(serial_accept), .load_done(load_done),
    .offset_level_dac(ofs_dac), .span_dac(span_dac),
    .offset_temp_coeff_dac(otc_dac), .span_temp_coeff_dac(stc_dac),
    .configuration_one(cfg1), .configuration_two(cfg2)
  );

  pup_prog_model u_pup_prog_model (
    .clk(clk), .ctrl_word_rx(ctrl_word_rx),
    .init_byte_rx(init_byte_rx), .analog_cmd_rx(analog_cmd_rx)
  );

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic timeout(input string what);
    bad_count++;
    $display("mismatch %s expected done seen hang", what);
    report_and_stop();
  endtask : timeout

  task automatic chk_bit(input string what, input logic exp,
                         input logic got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_val(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  // Request stands until the rising edge at which ack is sampled high
  task automatic wb_cycle(input logic we, input logic [7:0] adr,
                          input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= 4'hF;
    wb_dat <= dat;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) timeout("bus ack");
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb_cycle

  task automatic fl_write(input logic [8:0] a, input logic [15:0] d);
    wb_cycle(1'b1, REG_FADDR, {23'h0, a});
    wb_cycle(1'b1, REG_FDATA, {16'h0, d});
  endtask : fl_write

  task automatic power_up(input logic [7:0] tidx);
    int n;
    n = 0;
    @(posedge clk);
    rst_n    <= 1'b0;
    temp_idx <= tidx;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    do begin
      @(negedge clk);
      n++;
      if (n > 100) timeout("autoload");
    end while (load_done !== 1'b1);
  endtask : power_up

  task automatic test_factory();
    power_up(8'h03);
    chk_bit("prog_mode", 1'b1, prog_mode);
    chk_bit("analog_mode", 1'b0, analog_mode);
    chk_val("otc_dac", 32'h0000_FFFF, {16'h0, otc_dac});
    chk_val("stc_dac", 32'h0000_FFFF, {16'h0, stc_dac});
    chk_val("cfg1", 32'h0000_FFFF, {16'h0, cfg1});
    chk_val("cfg2", 32'h0000_FFFF, {16'h0, cfg2});
    chk_bit("serial_accept", 1'b0, serial_accept);
    u_pup_prog_model.send_init();
    @(negedge clk);
    chk_bit("serial_accept", 1'b1, serial_accept);
    $display("test factory done");
  endtask : test_factory

  task automatic test_direct();
    wb_cycle(1'b1, REG_OFFSET_LEVEL_DAC, 32'h0000_A5A5);
    @(negedge clk);
    chk_val("ofs_dac", 32'h0000_A5A5, {16'h0, ofs_dac});
    wb_cycle(1'b0, REG_OFFSET_LEVEL_DAC, 32'h0000_0000);
    chk_val("offset_level_dac read", 32'h0000_A5A5, rd);
    wb_cycle(1'b0, 8'h3C, 32'h0000_0000);
    chk_val("unmapped read", 32'h0000_0000, rd);
    fl_write(OTC_ADDR, 16'h1234);
    fl_write(OFS_LUT_BASE + 9'd175, 16'h0F0F);
    fl_write(SPAN_LUT_BASE + 9'd175, 16'h5A5A);
    // Wait code 2 gives 5 byte times; repeat 1 needs two words
    fl_write(SETUP_ADDR, 16'h0012);
    // Bus go-analog command leaves programming mode
    wb_cycle(1'b1, REG_CMD, 32'h0000_0001);
    @(negedge clk);
    chk_bit("cmd analog_mode", 1'b1, analog_mode);
    chk_bit("cmd prog_mode", 1'b0, prog_mode);
    $display("test direct done");
  endtask : test_direct

  task automatic test_prompt();
    power_up(8'd200);
    u_pup_prog_model.send_ctrl(1, 0);
    @(negedge clk);
    chk_bit("prog_mode", 1'b0, prog_mode);
    u_pup_prog_model.send_ctrl(1, 0);
    @(negedge clk);
    chk_bit("prog_mode", 1'b1, prog_mode);
    chk_val("otc_dac", 32'h0000_1234, {16'h0, otc_dac});
    // Direct value must be replaced by the table refresh in analog mode
    wb_cycle(1'b1, REG_OFFSET_LEVEL_DAC, 32'h0000_1111);
    @(negedge clk);
    chk_val("ofs_dac direct", 32'h0000_1111, {16'h0, ofs_dac});
    u_pup_prog_model.send_analog();
    @(negedge clk);
    chk_bit("analog_mode", 1'b1, analog_mode);
    chk_bit("prog_mode", 1'b0, prog_mode);
    repeat (8) @(negedge clk);
    chk_val("ofs_dac", 32'h0000_0F0F, {16'h0, ofs_dac});
    chk_val("span_dac", 32'h0000_5A5A, {16'h0, span_dac});
    wb_cycle(1'b1, REG_OTC, 32'h0000_7777);
    @(negedge clk);
    chk_val("otc_dac", 32'h0000_1234, {16'h0, otc_dac});
    $display("test prompt done");
  endtask : test_prompt

  task automatic test_expiry();
    power_up(8'd200);
    // Clock enable low freezes the wait window past its normal end
    @(posedge clk);
    ce <= 1'b0;
    repeat (12) @(posedge clk);
    ce <= 1'b1;
    @(negedge clk);
    chk_bit("frozen analog_mode", 1'b0, analog_mode);
    chk_bit("frozen prog_mode", 1'b0, prog_mode);
    u_pup_prog_model.send_ctrl(1, 0);
    repeat (30) @(negedge clk);
    chk_bit("analog_mode", 1'b1, analog_mode);
    chk_bit("prog_mode", 1'b0, prog_mode);
    u_pup_prog_model.send_ctrl(2, 0);
    u_pup_prog_model.send_analog();
    @(negedge clk);
    chk_bit("prog_mode", 1'b0, prog_mode);
    wb_cycle(1'b0, REG_STATUS, 32'h0000_0000);
    chk_val("state", 32'h0000_0008, {28'h0, rd[3:0]});
    chk_val("span_dac", 32'h0000_5A5A, {16'h0, span_dac});
    $display("test expiry done");
  endtask : test_expiry

  initial begin
    test_factory();
    test_direct();
    test_prompt();
    test_expiry();
    report_and_stop();
  end
endmodule : test_pup_ctrl
